// file: common/awce_if.sv
// task-file and data link between host controller and drive
`timescale 1ns/1ps
interface awce_if;
   logic [8:0] tf_addr;
   logic [7:0] tf_wdata;
   logic tf_wr;
   logic tf_rd;
   logic [7:0] tf_rdata;
   logic [15:0] data;
   logic data_valid;
   logic data_ack;
   logic dmack;
   logic drq;
   logic dmarq;
   logic intrq;
   modport dev
   (
      input tf_addr, tf_wdata, tf_wr, tf_rd, data, data_valid, dmack,
      output tf_rdata, data_ack, drq, dmarq, intrq
   );
   modport host
   (
      output tf_addr, tf_wdata, tf_wr, tf_rd, data, data_valid, dmack,
      input tf_rdata, data_ack, drq, dmarq, intrq
   );
endinterface

// file: common/awce_pkg.sv
// constants and types shared by both ends of the write command engine
package awce_pkg;
   // task-file offsets
   localparam logic [8:0] TF_BASE = 9'h1f0;
   localparam logic [8:0] TF_ERR_FEAT = 9'h1f1;
   localparam logic [8:0] TF_SECT_CNT = 9'h1f2;
   localparam logic [8:0] TF_SECT_NUM = 9'h1f3;
   localparam logic [8:0] TF_CYL_LOW = 9'h1f4;
   localparam logic [8:0] TF_CYL_HIGH = 9'h1f5;
   localparam logic [8:0] TF_DRV_HEAD = 9'h1f6;
   localparam logic [8:0] TF_CMD_STAT = 9'h1f7;
   // host register offsets
   localparam logic [3:0] H_STATUS = 4'h0;
   localparam logic [3:0] H_TF_LAST = 4'h7;
   localparam logic [3:0] H_FETCH = 4'h8;
   localparam logic [3:0] H_RESULT = 4'h9;
   // command codes
   localparam logic [7:0] CMD_WR_SECT0 = 8'h30;
   localparam logic [7:0] CMD_WR_SECT1 = 8'h31;
   localparam logic [7:0] CMD_WR_MULT = 8'hc5;
   localparam logic [7:0] CMD_SET_MULT = 8'hc6;
   localparam logic [7:0] CMD_WR_DMA0 = 8'hca;
   localparam logic [7:0] CMD_WR_DMA1 = 8'hcb;
   // status and error fields
   localparam int ST_BSY_BIT = 7;
   localparam int ST_RDY_BIT = 6;
   localparam int ST_DRQ_BIT = 3;
   localparam int ST_ERR_BIT = 0;
   localparam logic [7:0] ER_ABORT = 8'h04;
   localparam logic [7:0] ER_MEDIUM = 8'h40;
   localparam int DH_LBA_BIT = 6;
   // geometry, counts and check-code constants
   localparam logic [8:0] MAX_SECTORS = 9'h100;
   localparam logic [7:0] WORD_LAST = 8'hff;
   localparam logic [7:0] SECT_PER_TRACK = 8'h3f;
   localparam logic [3:0] HEAD_LAST = 4'hf;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   // reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_SECT = 8'h01;
   typedef enum logic [1:0] {MED_DATA = 2'h0, MED_CRC = 2'h1, MED_ECC = 2'h2} awce_med_t;
   typedef enum logic [1:0] {MODE_PIO = 2'h0, MODE_MULT = 2'h1, MODE_DMA = 2'h2} awce_mode_t;
   typedef enum logic [2:0]
   {
      S_IDLE = 3'h0,
      S_SEEK = 3'h1,
      S_XFER = 3'h3,
      S_TAIL = 3'h2,
      S_WAIT = 3'h6
   } awce_state_t;
endpackage

// file: dv/awce_asserts.sv
// link checks between host end and drive end
`timescale 1ns/1ps
module awce_asserts
   import awce_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [8:0] tf_addr,
   input wire logic [7:0] tf_wdata,
   input wire logic tf_wr,
   input wire logic tf_rd,
   input wire logic [15:0] data,
   input wire logic data_valid,
   input wire logic data_ack,
   input wire logic dmack,
   input wire logic drq,
   input wire logic dmarq,
   input wire logic intrq
);
   logic cmd_wr;
   logic blk_on;
   logic [7:0] sc_seen;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   assign cmd_wr = tf_wr && (tf_addr == TF_CMD_STAT);
   // mirror of block mode, so an unset mode can be told apart
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         sc_seen <= 8'h00;
         blk_on <= 1'b0;
      end
      else if (tf_wr && tf_addr == TF_SECT_CNT)
      begin
         sc_seen <= tf_wdata;
      end
      else if (cmd_wr && tf_wdata == CMD_SET_MULT)
      begin
         blk_on <= (sc_seen != 8'h00);
      end
   end
   property p_pio_start;
      cmd_wr && (tf_wdata == CMD_WR_SECT0 || tf_wdata == CMD_WR_SECT1) |-> ##[1:40] $rose(drq);
   endproperty
   a_pio_start: assert property (p_pio_start) else $error("no drq after sector write");
   property p_dma_start;
      cmd_wr && (tf_wdata == CMD_WR_DMA0 || tf_wdata == CMD_WR_DMA1) |-> ##[1:40] ($rose(dmarq) && !drq);
   endproperty
   a_dma_start: assert property (p_dma_start) else $error("no dmarq after dma write");
   property p_mult_abort;
      cmd_wr && tf_wdata == CMD_WR_MULT && !blk_on |-> !drq throughout (##[1:6] $rose(intrq));
   endproperty
   a_mult_abort: assert property (p_mult_abort) else $error("block write without mode not aborted");
   property p_ack_cause;
      data_ack |-> $past(data_valid) && ($past(drq) || $past(dmarq));
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("word taken without request");
   property p_ack_pulse;
      data_ack |=> !data_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("word ack longer than one cycle");
   property p_valid_hold;
      data_valid && !data_ack |=> data_valid && $stable(data);
   endproperty
   a_valid_hold: assert property (p_valid_hold) else $error("word dropped before ack");
   property p_dma_ack;
      data_ack && $past(dmarq) |-> $past(dmack);
   endproperty
   a_dma_ack: assert property (p_dma_ack) else $error("dma word taken without dmack");
   property p_excl;
      !(drq && dmarq);
   endproperty
   a_excl: assert property (p_excl) else $error("drq and dmarq together");
   property p_dma_irq;
      $rose(intrq) |-> !dmarq;
   endproperty
   a_dma_irq: assert property (p_dma_irq) else $error("interrupt during dma transfer");
   property p_irq_clear;
      $fell(intrq) |-> $past(tf_rd) && $past(tf_addr) == TF_CMD_STAT;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("interrupt dropped without status read");
   c_pio: cover property ($rose(drq));
   c_dma: cover property ($rose(dmarq));
   c_irq: cover property ($rose(intrq));
   c_abort: cover property (cmd_wr && tf_wdata == CMD_WR_MULT && !blk_on);
endmodule

// file: dv/tb_ata_write_command_engine.sv
// bench: host end and drive end joined, medium modelled, registers and words checked
`timescale 1ns/1ps
module tb_ata_write_command_engine
   import awce_pkg::*;
();
   typedef struct {string name; logic [7:0] exp; logic [7:0] mask;} awce_note_t;
   localparam logic [55:0] M_OK = 56'hff_0f_ff_ff_ff_ff_00;
   localparam logic [55:0] M_ERR = 56'hff_00_00_00_00_00_ff;
   localparam logic [55:0] M_ST = 56'hff_00_00_00_00_00_00;
   logic i_clk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_word_valid = 1'b0;
   logic i_seek_done = 1'b0, i_sect_done = 1'b0, i_sect_err = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00;
   logic [15:0] i_word = 16'h0000;
   logic [7:0] o_rdata, o_sector;
   logic o_word_ready, o_seek, o_med_valid;
   logic [15:0] o_seek_cyl, o_med_word, seek_cyl;
   logic [15:0] w_exp, crc_exp = CRC_INIT, ecc_exp = 16'h0000;
   logic [3:0] o_head;
   logic [1:0] o_med_kind;
   logic [2:0] seek_d = 3'h0;
   logic rd_d = 1'b0, ecc_d = 1'b0, drq_d = 1'b0, intr_d = 1'b0;
   int fail_count = 0, tests_run = 0;
   int sect_cnt = 0, err_at = 99, seeks = 0, drq_rises = 0, intr_rises = 0, words = 0;
   string reg_name[7] = '{"error", "count", "sector", "cyl low", "cyl high", "drive head", "status"};
   awce_note_t notes[$];
   logic [15:0] wq[$];
   awce_if bus ();
   awce_host i_awce_host (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus.host), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_word(i_word),
      .i_word_valid(i_word_valid), .o_word_ready(o_word_ready));
   awce_drive i_awce_drive (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus.dev), .i_seek_done(i_seek_done),
      .i_sect_done(i_sect_done), .i_sect_err(i_sect_err), .o_seek(o_seek), .o_seek_cyl(o_seek_cyl),
      .o_head(o_head), .o_sector(o_sector), .o_med_valid(o_med_valid), .o_med_word(o_med_word),
      .o_med_kind(o_med_kind));
   awce_asserts i_awce_asserts (.i_clk(i_clk), .i_resetn(i_resetn), .tf_addr(bus.tf_addr),
      .tf_wdata(bus.tf_wdata), .tf_wr(bus.tf_wr), .tf_rd(bus.tf_rd), .data(bus.data),
      .data_valid(bus.data_valid), .data_ack(bus.data_ack), .dmack(bus.dmack), .drq(bus.drq),
      .dmarq(bus.dmarq), .intrq(bus.intrq));
   initial
   begin
      forever #25 i_clk = ~i_clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
      begin
         $display("ALL CHECKS OK");
      end
      else
      begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp_val(input string nm, input logic [15:0] e, input logic [15:0] s);
      tests_run++;
      if (s !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cmp_reg(input awce_note_t n);
      cmp_val(n.name, {8'h00, n.exp & n.mask}, {8'h00, o_rdata & n.mask});
   endtask
   task automatic cmp_word(input logic [15:0] e);
      cmp_val("medium word", e, o_med_word);
   endtask
   // reference check code, msb of each word first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
      logic [15:0] r;
      r = c;
      for (int b = 15; b >= 0; b--)
      begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ w[b]) ? CRC_POLY : 16'h0000);
      end
      return r;
   endfunction
   task automatic hw(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic hr(input logic [3:0] a, input string nm, input logic [7:0] e, input logic [7:0] m);
      notes.push_back('{nm, e, m});
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask
   // task-file values reach the host only through its fetch register
   task automatic fetch(input logic [3:0] off, input string nm, input logic [7:0] e, input logic [7:0] m);
      hw(H_FETCH, {4'h0, off});
      repeat (3) @(posedge i_clk);
      hr(H_RESULT, nm, e, m);
   endtask
   // f = {cmd, dh, ch, cl, sn, sc}; x and m = {st, dh, ch, cl, sn, sc, er}
   task automatic run(input logic [47:0] f, input int n, input int e, input int drqs,
      input logic [55:0] x, input logic [55:0] m);
      int t;
      t = 0;
      sect_cnt = 0;
      err_at = e;
      drq_rises = 0;
      intr_rises = 0;
      seeks = 0;
      words = 0;
      for (int i = 0; i < 6; i++)
      begin
         hw(4'(i + 2), f[i*8 +: 8]);
      end
      while (sect_cnt < n)
      begin
         @(posedge i_clk);
         t++;
         if (t > 20000)
         begin
            fail_count++;
            $display("[FAIL] sectors expected %0d seen %0d", n, sect_cnt);
            report_and_stop();
         end
      end
      repeat (6) @(posedge i_clk);
      cmp_val("data words", 16'(n * 256), 16'(words));
      cmp_val("drq rises", 16'(drqs), 16'(drq_rises));
      cmp_val("irq rises", 16'h0001, 16'(intr_rises));
      for (int i = 0; i < 7; i++)
      begin
         if (m[i*8 +: 8] != 8'h00)
         begin
            fetch(4'(i + 1), reg_name[i], x[i*8 +: 8], m[i*8 +: 8]);
         end
      end
      // sector and head pins must agree with the task file
      if (m[16 +: 8] != 8'h00)
      begin
         cmp_val("sector out", {8'h00, x[16 +: 8]}, {8'h00, o_sector});
         cmp_val("head out", {12'h000, x[40 +: 4]}, {12'h000, o_head});
      end
      repeat (4) @(posedge i_clk);
   endtask
   // medium model, word source and result watchers
   always @(posedge i_clk)
   begin
      seek_d <= {seek_d[1:0], o_seek};
      i_seek_done <= seek_d[2];
      ecc_d <= o_med_valid && (o_med_kind === MED_ECC);
      i_sect_done <= ecc_d;
      i_sect_err <= ecc_d && (sect_cnt == err_at);
      if (ecc_d)
         sect_cnt <= sect_cnt + 1;
      rd_d <= i_rd;
      drq_d <= bus.drq;
      intr_d <= bus.intrq;
      if (o_seek === 1'b1)
      begin
         seeks <= seeks + 1;
         seek_cyl <= o_seek_cyl;
      end
      if (bus.drq === 1'b1 && drq_d !== 1'b1)
         drq_rises <= drq_rises + 1;
      if (bus.intrq === 1'b1 && intr_d !== 1'b1)
         intr_rises <= intr_rises + 1;
      if (rd_d && notes.size() > 0)
         cmp_reg(notes.pop_front());
      if (o_med_valid === 1'b1 && o_med_kind === MED_DATA)
      begin
         words <= words + 1;
         w_exp = wq.size() > 0 ? wq.pop_front() : 16'hxxxx;
         cmp_word(w_exp);
         crc_exp = crc_step(crc_exp, w_exp);
         ecc_exp = {ecc_exp[14:0], ecc_exp[15]} ^ w_exp;
      end
      if (o_med_valid === 1'b1 && o_med_kind === MED_CRC)
         cmp_val("sector crc", crc_exp, o_med_word);
      // ecc closes a sector, so both sums restart for the next one
      if (o_med_valid === 1'b1 && o_med_kind === MED_ECC)
      begin
         cmp_val("sector ecc", ecc_exp, o_med_word);
         crc_exp = CRC_INIT;
         ecc_exp = 16'h0000;
      end
      // random stalls keep the host end slow now and then
      if (i_word_valid && o_word_ready === 1'b1)
      begin
         wq.push_back(i_word);
         i_word <= 16'($urandom);
         i_word_valid <= ($urandom % 4) != 0;
      end
      else if (!i_word_valid)
         i_word_valid <= 1'b1;
   end
   initial
   begin
      repeat (60000) @(posedge i_clk);
      fail_count++;
      $display("[FAIL] run length expected done seen hang");
      report_and_stop();
   end
   initial
   begin
      void'($urandom(24));
      repeat (12) @(posedge i_clk);
      i_resetn <= 1'b1;
      hr(H_STATUS, "host status", 8'h00, 8'hff);
      hr(4'hc, "unmapped", 8'h00, 8'hff);
      fetch(4'h3, "sector reset", RST_SECT, 8'hff);
      run({CMD_WR_SECT0, 40'h05_00_12_3f_02}, 2, 99, 2, 56'h40_06_00_12_01_00_00, M_OK);
      cmp_val("seeks", 16'h0001, 16'(seeks));
      cmp_val("seek cylinder", 16'h0012, seek_cyl);
      run({CMD_WR_SECT1, 40'h05_00_12_10_00}, 2, 1, 2, 56'h41_05_00_12_11_fe_40, 56'hff_0f_ff_ff_ff_ff_ff);
      cmp_val("seeks", 16'h0000, 16'(seeks));
      run({CMD_WR_MULT, 40'h40_00_12_20_03}, 0, 99, 0, 56'h41_00_00_00_00_00_04, M_ERR);
      run({CMD_SET_MULT, 40'h40_00_12_20_02}, 0, 99, 0, 56'h40_00_00_00_00_00_00, M_ST);
      run({CMD_WR_MULT, 40'h40_00_12_20_03}, 3, 99, 2, 56'h40_00_00_12_22_00_00, M_OK);
      run({CMD_WR_MULT, 40'h40_00_12_30_01}, 1, 99, 1, 56'h40_00_00_12_30_00_00, M_OK);
      // error inside the first block; the word already offered waits for the retry
      run({CMD_WR_MULT, 40'h40_00_12_60_04}, 1, 0, 1, 56'h41_00_00_00_00_00_40, M_ERR);
      run({CMD_WR_SECT0, 40'h40_00_12_60_01}, 1, 99, 1, 56'h40_00_00_12_60_00_00, M_OK);
      run({CMD_WR_DMA0, 40'h40_12_34_40_02}, 2, 99, 0, 56'h40_00_12_34_41_00_00, M_OK);
      cmp_val("seek cylinder", 16'h1234, seek_cyl);
      run({CMD_WR_DMA1, 40'h40_12_34_50_02}, 1, 0, 0, 56'h41_00_00_00_00_00_40, M_ERR);
      report_and_stop();
   end
endmodule

// file: rtl/awce_crc.sv
// per-sector crc and ecc accumulator over data words
`timescale 1ns/1ps
module awce_crc
   import awce_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_clear,
   input wire logic i_valid,
   input wire logic [15:0] i_word,
   output logic [15:0] o_crc,
   output logic [15:0] o_ecc
);
   typedef struct packed
   {
      logic [15:0] crc;
      logic [15:0] ecc;
   } awce_crc_t;
   awce_crc_t s;
   awce_crc_t next_s;
   logic [16:0][15:0] chain;

   assign chain[0] = s.crc;
   // one bit per stage so a whole word folds in one cycle
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++)
      begin : g_bit
         assign chain[gi + 1] = {chain[gi][14:0], 1'b0} ^
            ((chain[gi][15] ^ i_word[15 - gi]) ? CRC_POLY : 16'h0000);
      end
   endgenerate

   always_comb
   begin
      next_s = s;
      if (i_clear)
      begin
         next_s.crc = CRC_INIT;
         next_s.ecc = 16'h0000;
      end
      else if (i_valid)
      begin
         next_s.crc = chain[16];
         next_s.ecc = {s.ecc[14:0], s.ecc[15]} ^ i_word;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         s <= '{crc: CRC_INIT, ecc: 16'h0000};
      else
         s <= next_s;
   end

   assign o_crc = s.crc;
   assign o_ecc = s.ecc;
endmodule

// file: rtl/awce_drive.sv
// drive end: task file, write command decode, sector sequencing
`timescale 1ns/1ps
module awce_drive
   import awce_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   awce_if.dev bus,
   input wire logic i_seek_done,
   input wire logic i_sect_done,
   input wire logic i_sect_err,
   output logic o_seek,
   output logic [15:0] o_seek_cyl,
   output logic [3:0] o_head,
   output logic [7:0] o_sector,
   output logic o_med_valid,
   output logic [15:0] o_med_word,
   output logic [1:0] o_med_kind
);
   typedef struct packed
   {
      awce_state_t st;
      awce_mode_t mode;
      logic [7:0] sc;
      logic [7:0] sn;
      logic [7:0] cl;
      logic [7:0] ch;
      logic [7:0] dh;
      logic [7:0] err;
      logic [7:0] blk;
      logic errf;
      logic bsy;
      logic drq;
      logic dmarq;
      logic intrq;
      logic [8:0] rem;
      logic [7:0] inblk;
      logic [7:0] wcnt;
      logic tail;
      logic [15:0] cur_cyl;
      logic [7:0] rdata;
      logic ack;
      logic seek;
      logic medv;
      logic [15:0] medw;
      awce_med_t medk;
   } awce_dev_t;
   awce_dev_t s;
   awce_dev_t next_s;
   logic take;
   logic [15:0] crc;
   logic [15:0] ecc;

   function automatic logic [7:0] awce_first_blk(input logic [7:0] per, input logic [8:0] r);
      logic [7:0] v;
      v = per;
      if ({1'b0, per} > r)
         v = r[7:0];
      return v;
   endfunction

   // address word is {dh, ch, cl, sn}; in lba mode its low 28 bits are the lba
   function automatic logic [31:0] awce_step(input logic [31:0] a);
      logic [31:0] r;
      r = a;
      if (a[24 + DH_LBA_BIT])
         r[27:0] = a[27:0] + 28'h0000001;
      else if (a[7:0] != SECT_PER_TRACK)
         r[7:0] = a[7:0] + 8'h01;
      else
      begin
         r[7:0] = RST_SECT;
         if (a[27:24] != HEAD_LAST)
            r[27:24] = a[27:24] + 4'h1;
         else
         begin
            r[27:24] = 4'h0;
            r[23:8] = a[23:8] + 16'h0001;
         end
      end
      return r;
   endfunction

   assign take = (s.st == S_XFER) && bus.data_valid && !s.ack && (s.mode != MODE_DMA || bus.dmack);

   awce_crc u_crc
   (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_clear(s.st == S_WAIT),
      .i_valid(take),
      .i_word(bus.data),
      .o_crc(crc),
      .o_ecc(ecc)
   );

   always_comb
   begin
      logic go;
      logic arm;
      logic irq;
      logic [8:0] rem_v;
      logic [7:0] per;
      logic [31:0] nxt;
      go = 1'b0;
      arm = 1'b0;
      irq = 1'b0;
      rem_v = 9'h000;
      per = (s.mode == MODE_MULT) ? s.blk : 8'h01;
      nxt = awce_step({s.dh, s.ch, s.cl, s.sn});
      next_s = s;
      next_s.ack = 1'b0;
      next_s.seek = 1'b0;
      next_s.medv = 1'b0;
      if (bus.tf_rd)
      begin
         case (bus.tf_addr)
            TF_ERR_FEAT: next_s.rdata = s.err;
            TF_SECT_CNT: next_s.rdata = s.sc;
            TF_SECT_NUM: next_s.rdata = s.sn;
            TF_CYL_LOW: next_s.rdata = s.cl;
            TF_CYL_HIGH: next_s.rdata = s.ch;
            TF_DRV_HEAD: next_s.rdata = s.dh;
            TF_CMD_STAT:
            begin
               next_s.rdata = 8'h00;
               next_s.rdata[ST_BSY_BIT] = s.bsy;
               next_s.rdata[ST_RDY_BIT] = !s.bsy;
               next_s.rdata[ST_DRQ_BIT] = s.drq;
               next_s.rdata[ST_ERR_BIT] = s.errf;
               // reading status acknowledges the interrupt
               next_s.intrq = 1'b0;
            end
            default: next_s.rdata = 8'h00;
         endcase
      end
      // writes while busy are dropped; the host must wait for busy to fall
      if (bus.tf_wr && !s.bsy)
      begin
         case (bus.tf_addr)
            TF_SECT_CNT: next_s.sc = bus.tf_wdata;
            TF_SECT_NUM: next_s.sn = bus.tf_wdata;
            TF_CYL_LOW: next_s.cl = bus.tf_wdata;
            TF_CYL_HIGH: next_s.ch = bus.tf_wdata;
            TF_DRV_HEAD: next_s.dh = bus.tf_wdata;
            TF_CMD_STAT:
            begin
               next_s.err = 8'h00;
               next_s.errf = 1'b0;
               rem_v = (s.sc == 8'h00) ? MAX_SECTORS : {1'b0, s.sc};
               next_s.rem = rem_v;
               next_s.wcnt = 8'h00;
               next_s.tail = 1'b0;
               nxt = {s.dh, s.ch, s.cl, s.sn};
               go = 1'b1;
               case (bus.tf_wdata)
                  CMD_WR_SECT0, CMD_WR_SECT1: next_s.mode = MODE_PIO;
                  CMD_WR_MULT: next_s.mode = MODE_MULT;
                  CMD_WR_DMA0, CMD_WR_DMA1: next_s.mode = MODE_DMA;
                  CMD_SET_MULT:
                  begin
                     next_s.blk = s.sc;
                     next_s.intrq = 1'b1;
                     go = 1'b0;
                  end
                  default: go = 1'b0;
               endcase
               if ((bus.tf_wdata == CMD_WR_MULT && s.blk == 8'h00) || (!go && bus.tf_wdata != CMD_SET_MULT))
               begin
                  next_s.err = ER_ABORT;
                  next_s.errf = 1'b1;
                  next_s.intrq = 1'b1;
                  go = 1'b0;
               end
               next_s.bsy = go;
               next_s.inblk = awce_first_blk((bus.tf_wdata == CMD_WR_MULT) ? s.blk : 8'h01, rem_v);
            end
            default: next_s.sc = s.sc;
         endcase
      end
      case (s.st)
         S_IDLE: next_s.st = S_IDLE;
         S_SEEK:
         begin
            if (i_seek_done)
            begin
               next_s.cur_cyl = {s.ch, s.cl};
               arm = 1'b1;
            end
         end
         S_XFER:
         begin
            if (take)
            begin
               next_s.ack = 1'b1;
               next_s.medv = 1'b1;
               next_s.medw = bus.data;
               next_s.medk = MED_DATA;
               next_s.wcnt = s.wcnt + 8'h01;
               if (s.wcnt == WORD_LAST)
               begin
                  next_s.st = S_TAIL;
                  if (s.mode != MODE_DMA && s.inblk == 8'h01)
                     next_s.drq = 1'b0;
                  if (s.rem == 9'h001)
                     next_s.dmarq = 1'b0;
               end
            end
         end
         S_TAIL:
         begin
            next_s.medv = 1'b1;
            next_s.tail = !s.tail;
            next_s.medw = s.tail ? ecc : crc;
            next_s.medk = s.tail ? MED_ECC : MED_CRC;
            if (s.tail)
               next_s.st = S_WAIT;
         end
         S_WAIT:
         begin
            if (i_sect_done && i_sect_err)
            begin
               // address still names the failing sector; nothing further is asked for
               next_s.err = ER_MEDIUM;
               next_s.errf = 1'b1;
               next_s.sc = 8'(s.rem - 9'h001);
               next_s.drq = 1'b0;
               next_s.dmarq = 1'b0;
               next_s.bsy = 1'b0;
               next_s.intrq = 1'b1;
               next_s.st = S_IDLE;
            end
            else if (i_sect_done && s.rem == 9'h001)
            begin
               next_s.sc = 8'h00;
               next_s.bsy = 1'b0;
               next_s.intrq = 1'b1;
               next_s.st = S_IDLE;
            end
            else if (i_sect_done)
            begin
               next_s.rem = s.rem - 9'h001;
               next_s.sc = 8'(s.rem - 9'h001);
               next_s.wcnt = 8'h00;
               go = 1'b1;
               if (s.inblk == 8'h01)
               begin
                  next_s.inblk = awce_first_blk(per, s.rem - 9'h001);
                  irq = (s.mode != MODE_DMA);
               end
               else
                  next_s.inblk = s.inblk - 8'h01;
            end
         end
         default: next_s.st = S_IDLE;
      endcase
      if (go)
      begin
         {next_s.dh, next_s.ch, next_s.cl, next_s.sn} = nxt;
         next_s.intrq = next_s.intrq | irq;
         if (nxt[23:8] != s.cur_cyl)
         begin
            next_s.st = S_SEEK;
            next_s.seek = 1'b1;
         end
         else
            arm = 1'b1;
      end
      if (arm)
      begin
         next_s.st = S_XFER;
         if (next_s.mode == MODE_DMA)
            next_s.dmarq = 1'b1;
         else
            next_s.drq = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         s <= '0;
         s.st <= S_IDLE;
         s.sn <= RST_SECT;
      end
      else
         s <= next_s;
   end

   assign bus.tf_rdata = s.rdata;
   assign bus.data_ack = s.ack;
   assign bus.drq = s.drq;
   assign bus.dmarq = s.dmarq;
   assign bus.intrq = s.intrq;
   assign o_seek = s.seek;
   assign o_seek_cyl = {s.ch, s.cl};
   assign o_head = s.dh[3:0];
   assign o_sector = s.sn;
   assign o_med_valid = s.medv;
   assign o_med_word = s.medw;
   assign o_med_kind = s.medk;
endmodule

// file: rtl/awce_host.sv
// host end: register port to task file, word pacing on drq or dmarq
`timescale 1ns/1ps
module awce_host
   import awce_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_resetn,
   awce_if.host bus,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic [15:0] i_word,
   input wire logic i_word_valid,
   output logic o_word_ready
);
   typedef struct packed
   {
      logic [8:0] tf_addr;
      logic [7:0] tf_wdata;
      logic tf_wr;
      logic tf_rd;
      logic rd_wait;
      logic [7:0] result;
      logic [7:0] rdata;
      logic [15:0] word;
      logic pend;
      logic dmack;
      logic ready;
   } awce_host_t;
   awce_host_t s;
   awce_host_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.tf_wr = 1'b0;
      next_s.tf_rd = 1'b0;
      next_s.rd_wait = s.tf_rd;
      if (s.rd_wait)
         next_s.result = bus.tf_rdata;
      // address and count go out before the command, in write order
      if (i_wr && i_addr != H_STATUS && i_addr <= H_TF_LAST)
      begin
         next_s.tf_wr = 1'b1;
         next_s.tf_addr = TF_BASE | {5'h00, i_addr};
         next_s.tf_wdata = i_wdata;
      end
      else if (i_wr && i_addr == H_FETCH)
      begin
         next_s.tf_rd = 1'b1;
         next_s.tf_addr = TF_BASE | {5'h00, i_wdata[3:0]};
      end
      next_s.rdata = 8'h00;
      if (i_rd)
      begin
         case (i_addr)
            H_STATUS: next_s.rdata = {3'h0, s.pend, s.tf_rd | s.rd_wait, bus.dmarq, bus.drq, bus.intrq};
            H_RESULT: next_s.rdata = s.result;
            default: next_s.rdata = 8'h00;
         endcase
      end
      // a word stays offered until the drive acknowledges it
      if (bus.data_ack)
      begin
         next_s.pend = 1'b0;
         next_s.dmack = 1'b0;
      end
      if (s.ready && i_word_valid)
      begin
         next_s.pend = 1'b1;
         next_s.word = i_word;
         next_s.dmack = bus.dmarq;
      end
      next_s.ready = (bus.drq | bus.dmarq) && !next_s.pend;
   end

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         s <= '0;
      else
         s <= next_s;
   end

   assign bus.tf_addr = s.tf_addr;
   assign bus.tf_wdata = s.tf_wdata;
   assign bus.tf_wr = s.tf_wr;
   assign bus.tf_rd = s.tf_rd;
   assign bus.data = s.word;
   assign bus.data_valid = s.pend;
   assign bus.dmack = s.dmack;
   assign o_rdata = s.rdata;
   assign o_word_ready = s.ready;
endmodule
